// ==== hw/ohtm_top.sv ====
// Overheat pin monitor: pin roles, assertion timer, limits, pin drive
// How it works
// R1 - Alert is inactive after reset; config3 bit 0 turns pin one into alert.
// R2 - Config4 bits 1:0 pick pin two role: tach, overheat, alert, GPIO.
// R3 - Overheat role monitors and times only while config3 bit 1 is set.
// R4 - Latch variant latches 0.25 above selected remote limit, boosting fans.
// R5 - Latch holds until temperature is below limit and status bit 0 cleared.
// R6 - Latch variant limits reset to 136 for remote 2, 100 for remote 1.
// R7 - Full_duty_on_overheat bit with pin low requests full duty for running fans.
// R8 - Timer counts only while asserted, pauses, resumes from held value.
// R9 - Reading the timer clears it; it saturates at full scale.
// R10 - Bit 0 sets on first assertion; one LSB is 22.76 ms.
// R11 - Read while asserted reseeds one; zero limit sets the flag.
// R12 - Timer above limit sets status bit 5 and raises alert.
// R13 - Mask bit 5 suppresses the alert but the flag still sets.
// R14 - Limit 0 alerts on first assertion, limit 1 after 45.52 ms.
// R15 - Config5 bits 5..7 enable pin drive per channel; else input only.
// R16 - Timer also counts external lows while the device is not driving.
// R17 - Channel over limit by 0.25 drives pin low until a reading clears.
// R18 - Three overheat limit registers sit at consecutive addresses.
// R19 - Drive is off for floor limits or when config3 bit 1 is clear.
// R20 - Status bit 5 sticks until condition ends and status is read; bit 0 clears on a status read; bit 1 follows the drive flags.
// R21 - Pin input is synchronised; timer advances on an internal tick.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "ohtm_consts.svh"
module ohtm_top #(
  parameter bit LATCH_VARIANT = 1'b0,
  parameter int TICK_CYCLES = `OHTM_LSB_NS / `OHTM_CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Temperature readings, quarter degree, one strobe per monitoring cycle
  input wire logic [9:0] temp_remote1,
  input wire logic [9:0] temp_local,
  input wire logic [9:0] temp_remote2,
  input wire logic [2:0] temp_valid,
  // Multi-purpose pin one, open drain
  output logic pin1_o,
  output logic pin1_oe,
  // Multi-purpose pin two, open drain
  input wire logic pin2_i,
  output logic pin2_o,
  output logic pin2_oe,
  // Fan side
  output logic fan4_speed_input,
  output logic full_duty_on_overheat,
  output logic overheat_hold_output
);

  ohtm_tmr_if tif ();

  logic [7:0] lim_reg [3];
  logic [7:0] lim_next [3];
  logic [7:0] mask2_reg;
  logic [7:0] mask2_next;
  logic [7:0] cfg3_reg;
  logic [7:0] cfg3_next;
  logic [7:0] cfg4_reg;
  logic [7:0] cfg4_next;
  logic [7:0] cfg5_reg;
  logic [7:0] cfg5_next;
  logic [7:0] tlim_reg;
  logic [7:0] tlim_next;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic ack_reg;
  logic ack_next;
  logic sync1_reg;
  logic sync2_reg;
  logic [2:0] drv_reg;
  logic [2:0] drv_next;
  logic latch_reg;
  logic latch_next;
  logic alert_reg;
  logic alert_next;
  logic pin1_oe_reg;
  logic pin1_oe_next;
  logic pin2_oe_reg;
  logic pin2_oe_next;
  logic tach_reg;
  logic tach_next;
  logic full_reg;
  logic full_next;

  logic [9:0] temp [3];
  logic [2:0] over;
  logic [2:0] below;
  logic [2:0] at_or_below;
  logic [2:0] lim_off;
  ohtm_pkg::ohtm_role_e role;
  logic heat_en;
  logic take;
  logic [7:0] idx;
  logic rd_stat;
  logic tlim_cond;
  logic latch_set;
  logic [1:0] lsel;

  assign temp[0] = temp_remote1;
  assign temp[1] = temp_local;
  assign temp[2] = temp_remote2;

  // Pin two passes two flops before anything reads it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin2_i; // [R21]
      sync2_reg <= sync1_reg;
    end
  end

  assign role = ohtm_pkg::ohtm_role_e'(cfg4_reg[1:0]); // [R2]
  assign heat_en = (role == ohtm_pkg::OHTM_ROLE_HEAT) &&
                   cfg3_reg[`OHTM_CFG3_HEAT_EN]; // [R3]
  // Pin level is read, so external lows count as well as our own [R16]
  assign tif.active = heat_en && !sync2_reg;

  // Per-channel comparison against limit, in quarter degrees
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_chan
      logic [9:0] t_key;
      logic [9:0] l_key;
      // Two's complement is compared as offset by flipping the sign bit
      assign t_key = cfg5_reg[`OHTM_CFG5_OFFSET] ? temp[g] :
                     temp[g] ^ `OHTM_SIGN_FLIP;
      assign l_key = cfg5_reg[`OHTM_CFG5_OFFSET] ? {lim_reg[g], 2'b00} :
                     {lim_reg[g], 2'b00} ^ `OHTM_SIGN_FLIP;
      assign over[g] = t_key > l_key; // [R17] [R4]
      assign below[g] = t_key < l_key;
      assign at_or_below[g] = t_key <= l_key;
      // Floor limit switches the drive off [R19]
      assign lim_off[g] = cfg5_reg[`OHTM_CFG5_OFFSET] ?
                          (lim_reg[g] == `OHTM_DIS_OFFSET) :
                          (lim_reg[g] == `OHTM_DIS_TWOS);
    end
  endgenerate

  // Bus decode
  assign take = wb_cyc_i && wb_stb_i && !ack_reg;
  assign idx = wb_adr_i[9:2];
  assign rd_stat = take && !wb_we_i && (idx == `OHTM_IDX_STAT2);
  assign tif.rd_clear = take && !wb_we_i && (idx == `OHTM_IDX_TIMER); // [R9]
  assign tlim_cond = heat_en && (tif.count > tlim_reg); // [R12] [R14]
  assign lsel = cfg4_reg[`OHTM_CFG4_LATCH_SEL] ? 2'd2 : 2'd0;
  assign latch_set = LATCH_VARIANT && !latch_reg && temp_valid[lsel] &&
                     over[lsel];

  // Register file: one always_comb for writes and read data
  always_comb
  begin
    lim_next = lim_reg;
    mask2_next = mask2_reg;
    cfg3_next = cfg3_reg;
    cfg4_next = cfg4_reg;
    cfg5_next = cfg5_reg;
    tlim_next = tlim_reg;
    dat_next = dat_reg;
    ack_next = take;
    if (take && wb_we_i && wb_sel_i[0])
    begin
      if (idx == `OHTM_IDX_LIM_R1) // [R18]
        lim_next[0] = wb_dat_i[7:0];
      else if (idx == `OHTM_IDX_LIM_LOC)
        lim_next[1] = wb_dat_i[7:0];
      else if (idx == `OHTM_IDX_LIM_R2)
        lim_next[2] = wb_dat_i[7:0];
      else if (idx == `OHTM_IDX_MASK2)
        mask2_next = wb_dat_i[7:0];
      else if (idx == `OHTM_IDX_CFG3)
        cfg3_next = wb_dat_i[7:0];
      else if (idx == `OHTM_IDX_TLIM)
        tlim_next = wb_dat_i[7:0];
      else if (idx == `OHTM_IDX_CFG5)
        cfg5_next = wb_dat_i[7:0];
      else if (idx == `OHTM_IDX_CFG4)
        cfg4_next = wb_dat_i[7:0];
    end
    if (take && !wb_we_i)
    begin
      // Unmapped and status-only bits read as zero
      dat_next = '0;
      if (idx == `OHTM_IDX_LIM_R1)
        dat_next[7:0] = lim_reg[0];
      else if (idx == `OHTM_IDX_LIM_LOC)
        dat_next[7:0] = lim_reg[1];
      else if (idx == `OHTM_IDX_LIM_R2)
        dat_next[7:0] = lim_reg[2];
      else if (idx == `OHTM_IDX_STAT2)
        dat_next[7:0] = stat_reg;
      else if (idx == `OHTM_IDX_MASK2)
        dat_next[7:0] = mask2_reg;
      else if (idx == `OHTM_IDX_CFG3)
        dat_next[7:0] = cfg3_reg;
      else if (idx == `OHTM_IDX_TIMER)
        dat_next[7:0] = tif.count;
      else if (idx == `OHTM_IDX_TLIM)
        dat_next[7:0] = tlim_reg;
      else if (idx == `OHTM_IDX_CFG5)
        dat_next[7:0] = cfg5_reg;
      else if (idx == `OHTM_IDX_CFG4)
        dat_next[7:0] = cfg4_reg;
    end
  end

  // Monitor state: drive flags, latch, status, alert and pins
  always_comb
  begin
    drv_next = drv_reg;
    latch_next = latch_reg;
    stat_next = stat_reg;
    // Flags only move on a fresh reading or a disable, so a drive holds until then
    for (int i = 0; i < 3; i++)
    begin
      if (!cfg5_reg[`OHTM_CFG5_DRV_LSB + i] || lim_off[i] || !heat_en)
        drv_next[i] = 1'b0; // [R15] [R19]
      else if (temp_valid[i] && over[i])
        drv_next[i] = 1'b1; // [R17]
      else if (temp_valid[i] && at_or_below[i])
        drv_next[i] = 1'b0; // [R17]
    end
    if (latch_set)
      latch_next = 1'b1; // [R4]
    else if (latch_reg && temp_valid[lsel] && below[lsel] &&
             !stat_reg[`OHTM_STAT_LATCH])
      latch_next = 1'b0; // [R5]
    // A new event wins over the read that would clear it
    stat_next[`OHTM_STAT_LATCH] = latch_set ||
      (stat_reg[`OHTM_STAT_LATCH] && !rd_stat); // [R5]
    stat_next[`OHTM_STAT_OVT] = |drv_reg;
    stat_next[`OHTM_STAT_TLIM] = tlim_cond ||
      (stat_reg[`OHTM_STAT_TLIM] && !rd_stat); // [R20] [R11]
    // Mask blocks only the alert, never the flag [R13]
    alert_next = |(stat_reg & ~mask2_reg & `OHTM_ALERT_SOURCES); // [R12]
    pin1_oe_next = cfg3_reg[`OHTM_CFG3_ALERT] && alert_reg; // [R1]
    pin2_oe_next = (heat_en && (|drv_reg)) ||
                   ((role == ohtm_pkg::OHTM_ROLE_ALERT) && alert_reg);
    tach_next = (role == ohtm_pkg::OHTM_ROLE_TACH) ? sync2_reg : 1'b1;
    full_next = (cfg3_reg[`OHTM_CFG3_FULL_DUTY_ON_OVERHEAT] && tif.active) || // [R7]
                (latch_reg && !cfg4_reg[`OHTM_CFG4_NO_LATCH_FULL_DUTY_ON_OVERHEAT]); // [R4]
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      if (LATCH_VARIANT)
      begin
        lim_reg[0] <= `OHTM_LATCH_LIM_R1; // [R6]
        lim_reg[1] <= `OHTM_RST_LIM;
        lim_reg[2] <= `OHTM_LATCH_LIM_R2; // [R6]
      end
      else
      begin
        lim_reg[0] <= `OHTM_RST_LIM;
        lim_reg[1] <= `OHTM_RST_LIM;
        lim_reg[2] <= `OHTM_RST_LIM;
      end
      mask2_reg <= `OHTM_RST_CFG;
      cfg3_reg <= `OHTM_RST_CFG;
      cfg4_reg <= `OHTM_RST_CFG;
      cfg5_reg <= `OHTM_RST_CFG;
      tlim_reg <= `OHTM_RST_CFG;
      stat_reg <= `OHTM_RST_CFG;
      dat_reg <= '0;
      ack_reg <= 1'b0;
      drv_reg <= '0;
      latch_reg <= 1'b0;
      alert_reg <= 1'b0;
      pin1_oe_reg <= 1'b0;
      pin2_oe_reg <= 1'b0;
      tach_reg <= 1'b1;
      full_reg <= 1'b0;
    end
    else
    begin
      lim_reg <= lim_next;
      mask2_reg <= mask2_next;
      cfg3_reg <= cfg3_next;
      cfg4_reg <= cfg4_next;
      cfg5_reg <= cfg5_next;
      tlim_reg <= tlim_next;
      stat_reg <= stat_next;
      dat_reg <= dat_next;
      ack_reg <= ack_next;
      drv_reg <= drv_next;
      latch_reg <= latch_next;
      alert_reg <= alert_next;
      pin1_oe_reg <= pin1_oe_next;
      pin2_oe_reg <= pin2_oe_next;
      tach_reg <= tach_next;
      full_reg <= full_next;
    end
  end

  ohtm_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .t(tif.timer)
  );

  // Open-drain pins only ever pull low
  assign pin1_o = 1'b0;
  assign pin2_o = 1'b0;
  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign pin1_oe = pin1_oe_reg;
  assign pin2_oe = pin2_oe_reg;
  assign fan4_speed_input = tach_reg;
  assign full_duty_on_overheat = full_reg;
  assign overheat_hold_output = latch_reg;

endmodule

// ==== hw/ohtm_consts.svh ====
// Offsets, field positions, reset values and timing of the overheat monitor
`ifndef OHTM_CONSTS_SVH
`define OHTM_CONSTS_SVH

`define OHTM_IDX_LIM_R1 8'h6a
`define OHTM_IDX_LIM_LOC 8'h6b
`define OHTM_IDX_LIM_R2 8'h6c
`define OHTM_IDX_STAT2 8'h42
`define OHTM_IDX_MASK2 8'h75
`define OHTM_IDX_CFG3 8'h78
`define OHTM_IDX_TIMER 8'h79
`define OHTM_IDX_TLIM 8'h7a
`define OHTM_IDX_CFG5 8'h7c
`define OHTM_IDX_CFG4 8'h7d

`define OHTM_CFG3_ALERT 0
`define OHTM_CFG3_HEAT_EN 1
`define OHTM_CFG3_FULL_DUTY_ON_OVERHEAT 2
`define OHTM_CFG4_NO_LATCH_FULL_DUTY_ON_OVERHEAT 2
`define OHTM_CFG4_LATCH_SEL 3
`define OHTM_CFG5_OFFSET 0
`define OHTM_CFG5_DRV_LSB 5

`define OHTM_STAT_LATCH 0
`define OHTM_STAT_OVT 1
`define OHTM_STAT_TLIM 5
`define OHTM_ALERT_SOURCES 8'h22

`define OHTM_RST_CFG 8'h00
`define OHTM_RST_LIM 8'h64
`define OHTM_LATCH_LIM_R1 8'h64
`define OHTM_LATCH_LIM_R2 8'h88
`define OHTM_DIS_OFFSET 8'h00
`define OHTM_DIS_TWOS 8'h80
`define OHTM_SIGN_FLIP 10'h200
`define OHTM_CNT_FULL 8'hff
`define OHTM_CNT_ONE 8'h01

`define OHTM_CLK_NS 100
`define OHTM_LSB_NS 22760000

`endif

// ==== hw/ohtm_pkg.sv ====
// Types shared by the overheat monitor modules
package ohtm_pkg;

  typedef enum logic [1:0] {
    OHTM_ROLE_TACH = 2'b00,
    OHTM_ROLE_HEAT = 2'b01,
    OHTM_ROLE_ALERT = 2'b10,
    OHTM_ROLE_GPIO = 2'b11
  } ohtm_role_e;

  typedef logic [7:0] ohtm_byte_t;

endpackage

// ==== hw/ohtm_tmr_if.sv ====
// Link between the register logic and the assertion timer
`timescale 1ns/100ps
interface ohtm_tmr_if;
  logic active;
  logic rd_clear;
  ohtm_pkg::ohtm_byte_t count;

  modport timer (input active, input rd_clear, output count);
  modport ctrl (output active, output rd_clear, input count);
endinterface

// ==== hw/ohtm_timer.sv ====
// Cumulative assertion timer, clear on read, saturating
`timescale 1ns/100ps
`include "ohtm_consts.svh"
module ohtm_timer #(
  parameter int TICK_CYCLES = `OHTM_LSB_NS / `OHTM_CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control side
  ohtm_tmr_if.timer t
);

  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic seed_reg;
  logic seed_next;

  // The seeded first unit absorbs the first tick, so 45.52 ms reads as 2
  always_comb
  begin
    acc_next = acc_reg;
    count_next = count_reg;
    seed_next = seed_reg;
    if (t.rd_clear)
    begin
      // Read during assertion restarts from a seeded one [R11]
      acc_next = '0;
      count_next = t.active ? `OHTM_CNT_ONE : '0;
      seed_next = t.active;
    end
    else if (t.active)
    begin
      // Count only while asserted, held value resumes [R8]
      if (count_reg == '0)
      begin
        count_next = `OHTM_CNT_ONE; // [R10]
        seed_next = 1'b1;
      end
      if (acc_reg == 32'(TICK_CYCLES - 1))
      begin
        acc_next = '0;
        if (seed_reg)
          seed_next = 1'b0;
        else if (count_reg != `OHTM_CNT_FULL)
          count_next = count_reg + 8'h01; // [R9] [R10]
      end
      else
        acc_next = acc_reg + 32'h1; // [R21]
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      acc_reg <= '0;
      count_reg <= '0;
      seed_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      count_reg <= count_next;
      seed_reg <= seed_next;
    end
  end

  assign t.count = count_reg;

endmodule

// ==== sim/ohtm_pin_model.sv ====
// Far-side device sharing the open-drain overheat line
`timescale 1ns/100ps
module ohtm_pin_model (
  // Line control
  input wire logic pull_low,
  input wire logic dev_oe,
  // Resolved level
  output logic line
);
  // Pull-up: line is low while either party pulls, high once both let go
  assign line = ~(pull_low | dev_oe);
endmodule

// ==== sim/ohtm_chk.sv ====
// Port assertions for the overheat monitor
`timescale 1ns/100ps
`include "ohtm_consts.svh"
module ohtm_chk #(
  parameter bit LATCH_VARIANT = 1'b0,
  parameter int TICK_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and fan side
  input wire logic pin1_o,
  input wire logic pin1_oe,
  input wire logic pin2_i,
  input wire logic pin2_o,
  input wire logic pin2_oe,
  input wire logic fan4_speed_input,
  input wire logic full_duty_on_overheat,
  input wire logic overheat_hold_output
);
  logic [7:0] cfg3_reg, cfg3_next, cfg4_reg, cfg4_next;
  logic wr_take;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow of the two config registers, snooped from bus writes
  assign wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                   wb_sel_i[0];
  always_comb
  begin
    cfg3_next = cfg3_reg;
    cfg4_next = cfg4_reg;
    if (wr_take && wb_adr_i[9:2] == `OHTM_IDX_CFG3)
      cfg3_next = wb_dat_i[7:0];
    if (wr_take && wb_adr_i[9:2] == `OHTM_IDX_CFG4)
      cfg4_next = wb_dat_i[7:0];
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg3_reg <= `OHTM_RST_CFG;
      cfg4_reg <= `OHTM_RST_CFG;
    end
    else
    begin
      cfg3_reg <= cfg3_next;
      cfg4_reg <= cfg4_next;
    end
  end
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_HOLD: assert property (
    $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data changed outside a read");
  AST_DAT_UPPER: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_OPEN_DRAIN: assert property (!pin1_o && !pin2_o)
    else $error("pin driven high");
  AST_RST_QUIET: assert property (
    $fell(reset) |-> !pin1_oe && !pin2_oe)
    else $error("pin pulled right after reset");
  AST_ALERT_OFF: assert property (
    !cfg3_reg[0] && !$past(cfg3_reg[0]) |-> !pin1_oe)
    else $error("pin one pulled with alert off");
  AST_FAN4_ROLE: assert property (
    (cfg4_reg[1:0] != 2'b00)[*2] |-> fan4_speed_input)
    else $error("tach output active in other role");
  AST_TACH_FOLLOW: assert property (
    (cfg4_reg[1:0] == 2'b00)[*4] |->
    fan4_speed_input == $past(pin2_i, 3))
    else $error("tach output does not follow pin two");
  AST_PIN2_QUIET: assert property (
    (cfg4_reg[1:0] inside {2'b00, 2'b11})[*2] |-> !pin2_oe)
    else $error("pin two pulled in tach or gpio role");
  AST_FULL_DUTY_ON_OVERHEAT_GATE: assert property (
    full_duty_on_overheat |-> LATCH_VARIANT || $past(cfg3_reg[2]) ||
    $past(cfg3_reg[2], 2))
    else $error("full duty without full_duty_on_overheat");
  AST_HOLD_OFF: assert property (
    !LATCH_VARIANT |-> !overheat_hold_output)
    else $error("latch output without latch variant");
endmodule
bind ohtm_top ohtm_chk #(.LATCH_VARIANT(LATCH_VARIANT), .TICK_CYCLES(TICK_CYCLES))
  i_ohtm_chk (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin1_o, .pin1_oe, .pin2_i,
  .pin2_o, .pin2_oe, .fan4_speed_input, .full_duty_on_overheat,
  .overheat_hold_output);

// ==== sim/ohtm_top_tb.sv ====
// Self-checking bench for the overheat monitor
`timescale 1ns/100ps
`include "ohtm_consts.svh"
`define CHK(g, e) check_eq(32'(g), 32'(e))
module ohtm_top_tb;
  localparam int TK = 8;
  logic clk, reset, cyc, stb, we, pull;
  logic [9:0] adr;
  logic [31:0] dat_i;
  logic [2:0] tv;
  logic [9:0] tr [3];
  logic [7:0] rv;
  logic [31:0] dat_o;
  logic ack, p1o, p1oe, p2i, p2o, p2oe, fan4, full, hold;
  int num_errors, compares;
  ohtm_top #(.TICK_CYCLES(TK)) i_ohtm_top (.clk(clk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .temp_remote1(tr[0]), .temp_local(tr[1]), .temp_remote2(tr[2]),
    .temp_valid(tv), .pin1_o(p1o), .pin1_oe(p1oe), .pin2_i(p2i),
    .pin2_o(p2o), .pin2_oe(p2oe), .fan4_speed_input(fan4),
    .full_duty_on_overheat(full), .overheat_hold_output(hold));
  ohtm_pin_model i_ohtm_pin_model (.pull_low(pull), .dev_oe(p2oe),
    .line(p2i));
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      `CHK(0, 1);
    rv = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    `CHK(rv, exp);
  endtask
  // Far side pulls the line, then the bench lets time pass
  task automatic hold_low(input logic v, input int n);
    @(posedge clk);
    pull <= v;
    repeat (n) @(posedge clk);
  endtask
  // One reading strobe, then time for the drive flag to reach the pin
  task automatic temp(input int ch, input logic [9:0] v);
    @(posedge clk);
    tr[ch] <= v;
    tv[ch] <= 1'b1;
    @(posedge clk);
    tv <= 3'b000;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial
  begin
    reset = 1'b1;
    {cyc, stb, we, pull, tv} = '0;
    adr = '0;
    dat_i = '0;
    tr = '{default: 10'h000};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      rd(`OHTM_IDX_LIM_R1 + 8'(i), `OHTM_RST_LIM);
      bus(1'b1, `OHTM_IDX_LIM_R1 + 8'(i), 8'h70 + 8'(i));
    end
    for (int i = 0; i < 3; i++)
      rd(`OHTM_IDX_LIM_R1 + 8'(i), 8'h70 + 8'(i));
    rd(`OHTM_IDX_CFG3, `OHTM_RST_CFG);
    rd(`OHTM_IDX_CFG4, `OHTM_RST_CFG);
    rd(8'h10, 8'h00);
    bus(1'b1, `OHTM_IDX_TIMER, 8'h55);
    rd(`OHTM_IDX_TIMER, 8'h00);
    hold_low(1'b1, 30);
    `CHK(fan4, 1'b0);
    hold_low(1'b0, 5);
    rd(`OHTM_IDX_TIMER, 8'h00);
    bus(1'b1, `OHTM_IDX_CFG4, 8'h01);
    hold_low(1'b1, 30);
    hold_low(1'b0, 5);
    rd(`OHTM_IDX_TIMER, 8'h00);
    bus(1'b1, `OHTM_IDX_CFG3, 8'h02);
    // Two separate lows of under three ticks each must add up
    hold_low(1'b1, 22);
    hold_low(1'b0, 30);
    hold_low(1'b1, 22);
    hold_low(1'b0, 5);
    rd(`OHTM_IDX_TIMER, 8'h05);
    rd(`OHTM_IDX_TIMER, 8'h00);
    hold_low(1'b1, 12);
    hold_low(1'b0, 5);
    rd(`OHTM_IDX_TIMER, 8'h01);
    hold_low(1'b1, 20);
    rd(`OHTM_IDX_TIMER, 8'h02);
    rd(`OHTM_IDX_TIMER, 8'h01);
    hold_low(1'b0, 5);
    rd(`OHTM_IDX_TIMER, 8'h01);
    rd(`OHTM_IDX_TIMER, 8'h00);
    hold_low(1'b1, 2100);
    hold_low(1'b0, 5);
    rd(`OHTM_IDX_TIMER, 8'hff);
    bus(1'b1, `OHTM_IDX_TLIM, 8'h01);
    // Zero limit left the flag set earlier; clear it before the alert test
    rd(`OHTM_IDX_STAT2, 8'h20);
    bus(1'b1, `OHTM_IDX_CFG3, 8'h03);
    hold_low(1'b1, 10);
    `CHK(p1oe, 1'b0);
    hold_low(1'b1, 14);
    `CHK(p1oe, 1'b1);
    bus(1'b1, `OHTM_IDX_MASK2, 8'h20);
    hold_low(1'b0, 3);
    `CHK(p1oe, 1'b0);
    rd(`OHTM_IDX_STAT2, 8'h20);
    rd(`OHTM_IDX_STAT2, 8'h20);
    // 29 low cycles: seeded unit plus two whole ticks after the first
    rd(`OHTM_IDX_TIMER, 8'h03);
    rd(`OHTM_IDX_STAT2, 8'h20);
    rd(`OHTM_IDX_STAT2, 8'h00);
    bus(1'b1, `OHTM_IDX_MASK2, 8'h00);
    bus(1'b1, `OHTM_IDX_TLIM, 8'h00);
    hold_low(1'b1, 8);
    `CHK(p1oe, 1'b1);
    hold_low(1'b0, 3);
    rd(`OHTM_IDX_TIMER, 8'h01);
    rd(`OHTM_IDX_STAT2, 8'h20);
    bus(1'b1, `OHTM_IDX_CFG3, 8'h06);
    hold_low(1'b1, 8);
    `CHK(full, 1'b1);
    hold_low(1'b0, 6);
    `CHK(full, 1'b0);
    bus(1'b1, `OHTM_IDX_CFG3, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      temp(i, {8'h71 + 8'(i), 2'b01});
      `CHK(p2oe, 1'b0);
      bus(1'b1, `OHTM_IDX_CFG5, 8'h20 << i);
      temp(i, {8'h70 + 8'(i), 2'b01});
      `CHK(p2oe, 1'b1);
      temp(i, {8'h70 + 8'(i), 2'b00});
      `CHK(p2oe, 1'b0);
    end
    bus(1'b1, `OHTM_IDX_CFG5, 8'h20);
    bus(1'b1, `OHTM_IDX_LIM_R1, `OHTM_DIS_TWOS);
    temp(0, {8'h10, 2'b01});
    `CHK(p2oe, 1'b0);
    bus(1'b1, `OHTM_IDX_CFG5, 8'h21);
    bus(1'b1, `OHTM_IDX_LIM_R1, `OHTM_DIS_OFFSET);
    temp(0, {8'h10, 2'b01});
    `CHK(p2oe, 1'b0);
    bus(1'b1, `OHTM_IDX_LIM_R1, 8'h05);
    bus(1'b1, `OHTM_IDX_CFG3, 8'h00);
    temp(0, {8'h10, 2'b01});
    `CHK(p2oe, 1'b0);
    bus(1'b1, `OHTM_IDX_CFG3, 8'h02);
    temp(0, {8'h10, 2'b01});
    `CHK(p2oe, 1'b1);
    close_out();
  end
endmodule
